/* verilog/tsm_pkg.sv */
// package: register map, field layout and enumerations of the slave mode controller
package tsm_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam int                ADDR_W            = 8;
	localparam int                DATA_W            = 32;
	localparam logic [ADDR_W-1:0] OFS_COUNTER_CTRL  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_SLAVE_MODE    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_SLAVE_STATUS  = 8'h24;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SMC_SMS_LSB  = 0;
	localparam int SMC_OCCS_BIT = 3;
	localparam int SMC_TS_LSB   = 4;
	localparam int SMC_MSM_BIT  = 7;
	localparam int SMC_USED_W   = 8;
	localparam int CTL_RUN_BIT  = 0;
	localparam int STA_USED_W   = 3;

	// ------------------------------------------------------------
	// modes and sources, listed in encoding order
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SMS_DISABLED,
		SMS_ENCODER_1,
		SMS_ENCODER_2,
		SMS_ENCODER_3,
		SMS_RESET,
		SMS_GATED,
		SMS_TRIGGER,
		SMS_EXT_CLOCK
	} tsm_mode_t;

	typedef enum logic [2:0] {
		TS_INTERNAL_TRIGGER_0,
		TS_INTERNAL_TRIGGER_1,
		TS_INTERNAL_TRIGGER_2,
		TS_INTERNAL_TRIGGER_3,
		TS_TI1_EDGE,
		TS_TI1_FILT,
		TS_TI2_FILT,
		TS_RESERVED
	} tsm_src_t;

	typedef struct packed {
		logic      sync_delay_enable;
		tsm_src_t  trigger_source_select;
		logic      ref_clear_select;
		tsm_mode_t slave_mode_select;
	} tsm_smcr_t;

	localparam tsm_smcr_t SMCR_RESET = '0;

	typedef struct packed {
		logic step;
		logic down;
		logic reinit;
		logic update;
	} tsm_count_t;

endpackage : tsm_pkg

/* verilog/tsm_slave_ctrl.sv */
// module: timer slave mode controller with its register port
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// slave mode controller
// ------------------------------------------------------------
// Notes on behaviour
// R1: sync delay bit postpones trigger effects one cycle
// R2: trigger source field picks the trigger input
// R3: codes 000..011 pick internal triggers 0..3
// R4: 100 edge pulse, 101 input1, 110 input2
// R5: software changes source only while unused
// R6: clear source: pin when 0, external trigger 1
// R7: external trigger edge follows input polarity; the code inverts only input1 and input2, not filtered_external_trigger
// R8: mode 000: enable follows run bit only
// R9: mode 001: step on input2, direction from input1
// R10: mode 010: step on input1, direction from input2
// R11: mode 011: step on both, other sets direction
// R12: mode 100: rising edge reinitialises and updates
// R13: mode 101: run only while trigger high
// R14: mode 110: rising edge starts, never stops
// R15: mode 111: rising trigger edges clock counter
// R16: software avoids gated mode with edge pulse
// R17: edge pulse on every input1 transition
// R18: trigger 0 advanced timer, 3 timer14 compare
// R19: gated enable on trigger output delayed unless sync
// R20: trigger start sets the run bit
module tsm_slave_ctrl
	import tsm_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic              advanced_control_timer,
	input  wire logic              timer14_channel1_compare_out,
	input  wire logic              input1_filtered_raw,
	input  wire logic              filtered_input_1,
	input  wire logic              filtered_input_2,
	input  wire logic              input1_invert,
	input  wire logic              input2_invert,
	input  wire logic              ref_clear_pin_input,
	input  wire logic              filtered_external_trigger,
	output logic                   ref_clear_internal,
	output logic                   counter_enable,
	output logic                   trigger_output,
	output logic                   count_step,
	output logic                   count_down,
	output logic                   counter_reinit,
	output logic                   update_request,
	output logic                   input1_edge_pulse
);

	// ------------------------------------------------------------
	// functions
	// ------------------------------------------------------------
	// reserved internal triggers and the reserved code read as a quiet zero
	function automatic logic pick_trigger(tsm_src_t src, logic [3:0] itr, logic edge_p,
			logic ti1, logic ti2);
		logic res;
		res = 1'b0;
		unique case (src)
			TS_INTERNAL_TRIGGER_0, TS_INTERNAL_TRIGGER_1, TS_INTERNAL_TRIGGER_2, TS_INTERNAL_TRIGGER_3: res = itr[src[1:0]];
			TS_TI1_EDGE: res = edge_p;
			TS_TI1_FILT: res = ti1;
			TS_TI2_FILT: res = ti2;
			TS_RESERVED: res = 1'b0;
		endcase
		return res;
	endfunction : pick_trigger

	function automatic logic mode_is(tsm_smcr_t c, tsm_mode_t m);
		return c.slave_mode_select == m;
	endfunction : mode_is

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	tsm_smcr_t  smcr_q;
	logic       run_q;
	logic       run_d;
	logic       ti1_prev_q;
	logic       ti2_prev_q;
	logic       raw_prev_q;
	logic       edge_q;
	logic       trigger_input_prev_q;
	logic       rise_dly_q;
	logic       trigger_input_dly_q;
	logic       enable_prev_q;
	logic [3:0] itr;
	logic       ti1_pol;
	logic       ti2_pol;
	logic       trigger_input;
	logic       trig_rise;
	logic       eff_rise;
	logic       eff_level;
	logic       enable_d;
	tsm_count_t cnt_d;
	tsm_count_t cnt_q;
	logic       ti1_edge;
	logic       ti2_edge;
	logic       wr_ctl;
	logic       wr_smc;

	assign wr_ctl = reg_wr && reg_addr == OFS_COUNTER_CTRL;
	assign wr_smc = reg_wr && reg_addr == OFS_SLAVE_MODE;

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			smcr_q <= SMCR_RESET;
		end else if (wr_smc) begin
			// source may only be changed while unused; no guard in hardware (see R5)
			smcr_q <= tsm_smcr_t'(reg_wdata[SMC_USED_W-1:0]); // see R2
		end
	end

	// a trigger start in the same cycle as a software clear keeps the bit set
	always_comb begin
		run_d = run_q;
		if (wr_ctl) begin
			run_d = reg_wdata[CTL_RUN_BIT];
		end
		if (mode_is(smcr_q, SMS_TRIGGER) && eff_rise) begin
			run_d = 1'b1; // see R14 see R20
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			run_q <= 1'b0;
		end else begin
			run_q <= run_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				OFS_COUNTER_CTRL: reg_rdata <= DATA_W'(run_q);
				OFS_SLAVE_MODE:   reg_rdata <= DATA_W'(smcr_q);
				OFS_SLAVE_STATUS: reg_rdata <= DATA_W'({trigger_output, counter_enable, trigger_input});
				default:          reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// ------------------------------------------------------------
	// trigger selection
	// ------------------------------------------------------------
	assign itr     = {timer14_channel1_compare_out, 1'b0, 1'b0, advanced_control_timer}; // see R18
	assign ti1_pol = filtered_input_1 ^ input1_invert; // see R7
	assign ti2_pol = filtered_input_2 ^ input2_invert; // see R7
	assign trigger_input    = pick_trigger(smcr_q.trigger_source_select, itr, edge_q,
			ti1_pol, ti2_pol); // see R3 see R4

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			raw_prev_q <= 1'b0;
			edge_q     <= 1'b0;
		end else begin
			raw_prev_q <= input1_filtered_raw;
			edge_q     <= input1_filtered_raw ^ raw_prev_q; // see R17
		end
	end

	// the delayed copy lets this timer act one cycle late, in step with its slaves
	assign trig_rise = trigger_input && !trigger_input_prev_q;
	assign eff_rise  = smcr_q.sync_delay_enable ? rise_dly_q : trig_rise; // see R1
	assign eff_level = smcr_q.sync_delay_enable ? trigger_input_dly_q : trigger_input;      // see R1

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			trigger_input_prev_q <= 1'b0;
			rise_dly_q  <= 1'b0;
			trigger_input_dly_q  <= 1'b0;
		end else begin
			trigger_input_prev_q <= trigger_input;
			rise_dly_q  <= trig_rise;
			trigger_input_dly_q  <= trigger_input;
		end
	end

	// ------------------------------------------------------------
	// counter control
	// ------------------------------------------------------------
	assign ti1_edge = ti1_pol != ti1_prev_q;
	assign ti2_edge = ti2_pol != ti2_prev_q;

	always_comb begin
		cnt_d    = '0;
		enable_d = run_q;
		unique case (smcr_q.slave_mode_select)
			SMS_DISABLED: enable_d = run_q; // see R8
			SMS_ENCODER_1: begin
				cnt_d.step = run_q && ti2_edge;              // see R9
				cnt_d.down = ti1_pol ~^ ti2_pol;             // see R9
			end
			SMS_ENCODER_2: begin
				cnt_d.step = run_q && ti1_edge;              // see R10
				cnt_d.down = ti1_pol ^ ti2_pol;              // see R10
			end
			SMS_ENCODER_3: begin
				// simultaneous edges on both inputs are an illegal step and are dropped
				cnt_d.step = run_q && (ti1_edge ^ ti2_edge); // see R11
				cnt_d.down = ti1_edge ? (ti1_pol ^ ti2_pol) : (ti1_pol ~^ ti2_pol); // see R11
			end
			SMS_RESET: begin
				cnt_d.reinit = eff_rise; // see R12
				cnt_d.update = eff_rise; // see R12
			end
			// pulses from the edge detector open the gate for one cycle each; no guard in hardware (see R16)
			SMS_GATED:   enable_d = run_q && eff_level; // see R13
			SMS_TRIGGER: enable_d = run_d;              // see R14
			SMS_EXT_CLOCK: begin
				enable_d   = 1'b0;
				cnt_d.step = eff_rise; // see R15
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ti1_prev_q <= 1'b0;
			ti2_prev_q <= 1'b0;
			cnt_q      <= '0;
		end else begin
			ti1_prev_q <= ti1_pol;
			ti2_prev_q <= ti2_pol;
			cnt_q      <= cnt_d;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			counter_enable <= 1'b0;
			enable_prev_q  <= 1'b0;
			trigger_output <= 1'b0;
		end else begin
			counter_enable <= enable_d;
			enable_prev_q  <= enable_d;
			if (mode_is(smcr_q, SMS_GATED) && !smcr_q.sync_delay_enable) begin
				trigger_output <= enable_prev_q; // see R19
			end else begin
				trigger_output <= enable_d;      // see R19
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ref_clear_internal <= 1'b0;
		end else begin
			ref_clear_internal <= smcr_q.ref_clear_select ? filtered_external_trigger
					: ref_clear_pin_input; // see R6
		end
	end

	assign count_step        = cnt_q.step;
	assign count_down        = cnt_q.down;
	assign counter_reinit    = cnt_q.reinit;
	assign update_request    = cnt_q.update;
	assign input1_edge_pulse = edge_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	a_reset_reinit: assert property (mode_is(smcr_q, SMS_RESET) && eff_rise // see R12
			|=> counter_reinit && update_request)
		else $error("reset mode edge did not reinitialise");
	a_gate_hold: assert property (mode_is(smcr_q, SMS_GATED) && !eff_level // see R13
			|=> !counter_enable)
		else $error("gated counter ran with trigger low");
	a_trig_start: assert property (mode_is(smcr_q, SMS_TRIGGER) && eff_rise // see R20
			|=> run_q && counter_enable)
		else $error("trigger start did not set run bit");
	a_ext_clock: assert property (mode_is(smcr_q, SMS_EXT_CLOCK) && eff_rise // see R15
			|=> count_step && !counter_enable)
		else $error("external clock edge gave no step");
	a_clear_source: assert property (##1 ref_clear_internal == // see R6
			($past(smcr_q.ref_clear_select) ? $past(filtered_external_trigger)
			: $past(ref_clear_pin_input)))
		else $error("wrong clear source");
	a_sync_delay: assert property (mode_is(smcr_q, SMS_RESET) && smcr_q.sync_delay_enable // see R1
			&& trig_rise && !wr_smc |=> ##1 counter_reinit)
		else $error("delayed trigger effect missing");
	a_edge_pulse: assert property ($changed(input1_filtered_raw) // see R17
			|=> input1_edge_pulse)
		else $error("edge pulse missing");
	a_edge_idle: assert property (!$changed(input1_filtered_raw) // see R17
			|=> !input1_edge_pulse)
		else $error("edge pulse without a transition");
	a_enc_one: assert property (mode_is(smcr_q, SMS_ENCODER_1) && run_q && ti2_edge // see R9
			|=> count_step && count_down == $past(ti1_pol ~^ ti2_pol))
		else $error("encoder mode 1 step wrong");
	a_enc_two: assert property (mode_is(smcr_q, SMS_ENCODER_2) && run_q && ti1_edge // see R10
			|=> count_step && count_down == $past(ti1_pol ^ ti2_pol))
		else $error("encoder mode 2 step wrong");
	a_enc_three: assert property (mode_is(smcr_q, SMS_ENCODER_3) && run_q // see R11
			&& (ti1_edge ^ ti2_edge) |=> count_step)
		else $error("encoder mode 3 step missing");
	a_enc_idle: assert property (!run_q && smcr_q.slave_mode_select inside // see R11
			{SMS_ENCODER_1, SMS_ENCODER_2, SMS_ENCODER_3} |=> !count_step)
		else $error("encoder stepped with run bit clear");
	a_disabled_en: assert property (mode_is(smcr_q, SMS_DISABLED) // see R8
			|=> counter_enable == $past(run_q) && !count_step)
		else $error("disabled mode enable wrong");
	a_reserved_src: assert property (smcr_q.trigger_source_select == TS_RESERVED // see R4
			|-> !trigger_input)
		else $error("reserved source gave a trigger");
	a_itr_zero: assert property (smcr_q.trigger_source_select == TS_INTERNAL_TRIGGER_0 // see R3 R18
			|-> trigger_input == advanced_control_timer)
		else $error("internal trigger 0 not routed");
	a_itr_three: assert property (smcr_q.trigger_source_select == TS_INTERNAL_TRIGGER_3 // see R18
			|-> trigger_input == timer14_channel1_compare_out)
		else $error("internal trigger 3 not routed");
	a_itr_unused: assert property (smcr_q.trigger_source_select inside // see R18
			{TS_INTERNAL_TRIGGER_1, TS_INTERNAL_TRIGGER_2} |-> !trigger_input)
		else $error("unused internal trigger gave a trigger");
	a_ti2_source: assert property (smcr_q.trigger_source_select == TS_TI2_FILT // see R4 R7
			|-> trigger_input == (filtered_input_2 ^ input2_invert))
		else $error("input 2 source or polarity wrong");
	a_gate_view: assert property (mode_is(smcr_q, SMS_GATED) // see R19
			&& !smcr_q.sync_delay_enable |=> trigger_output == $past(counter_enable))
		else $error("gated enable not delayed for slaves");
	a_sync_view: assert property (mode_is(smcr_q, SMS_GATED) // see R1 R19
			&& smcr_q.sync_delay_enable |=> trigger_output == counter_enable)
		else $error("synchronised enable view lags");

	c_reset_mode: cover property (mode_is(smcr_q, SMS_RESET) && eff_rise ##1 counter_reinit);
	c_gated_run:  cover property (mode_is(smcr_q, SMS_GATED) ##1 counter_enable [*3]);
	c_trig_start: cover property (mode_is(smcr_q, SMS_TRIGGER) && eff_rise ##1 run_q);
	c_encoder3:   cover property (mode_is(smcr_q, SMS_ENCODER_3) ##1 count_step && count_down);

endmodule : tsm_slave_ctrl

`default_nettype wire

/* verification/tsm_far_side.sv */
// far side model: neighbouring timers and filtered input pins
`timescale 1ns/1ps
`default_nettype none
module tsm_far_side (
	input  wire logic       core_clk,
	input  wire logic [5:0] want,
	input  wire logic [1:0] slow,
	output logic            advanced_control_timer,
	output logic            timer14_channel1_compare_out,
	output logic            input1_filtered_raw,
	output logic            filtered_input_1,
	output logic            filtered_input_2,
	output logic            ref_clear_pin_input,
	output logic            filtered_external_trigger
);
	// ----
	// pin levels
	// ----
	logic [5:0] pins_q = 6'h00;
	logic [1:0] wait_q = 2'h0;
	// a slow answer stands for a neighbour whose output lags by a few cycles
	always_ff @(posedge core_clk) begin
		if (want == pins_q || wait_q == slow) begin
			pins_q <= want;
			wait_q <= 2'h0;
		end else begin
			wait_q <= wait_q + 2'h1;
		end
	end
	// the reserved internal triggers have no driver here; the controller ties them to zero
	assign advanced_control_timer       = pins_q[0];
	assign timer14_channel1_compare_out = pins_q[1];
	assign input1_filtered_raw          = pins_q[2];
	assign filtered_input_1             = pins_q[2];
	assign filtered_input_2             = pins_q[3];
	assign ref_clear_pin_input          = pins_q[4];
	assign filtered_external_trigger    = pins_q[5];
endmodule : tsm_far_side
`default_nettype wire

/* verification/timer_slave_mode_controller_test.sv */
// testbench: self-checking run of the slave mode controller
`timescale 1ns/1ps
`default_nettype none
module timer_slave_mode_controller_test;
	import tsm_pkg::*;
	// ----
	// signals and instances
	// ----
	logic              core_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 8'h00;
	logic [DATA_W-1:0] reg_wdata = 32'h0;
	logic              reg_wr = 1'b0;
	logic              reg_rd = 1'b0;
	logic              input1_invert = 1'b0;
	logic              input2_invert = 1'b0;
	logic [5:0]        want = 6'h00;
	logic [1:0]        slow = 2'h0;
	logic [DATA_W-1:0] reg_rdata;
	logic              advanced_control_timer, timer14_channel1_compare_out, input1_filtered_raw;
	logic              filtered_input_1, filtered_input_2, ref_clear_pin_input;
	logic              filtered_external_trigger, ref_clear_internal, counter_enable;
	logic              trigger_output, count_step, count_down, counter_reinit, update_request;
	logic              input1_edge_pulse;
	logic [5:0]        far;
	logic [2:0]        pulses;
	logic [5:0]        pin_of [8] = '{6'h01, 6'h0F, 6'h0F, 6'h02, 6'h04, 6'h04, 6'h08, 6'h0F};
	int                n_mismatch = 0;
	int                checks = 0;
	int                cycles = 0;
	assign far = {filtered_external_trigger, ref_clear_pin_input, filtered_input_2,
		filtered_input_1, timer14_channel1_compare_out, advanced_control_timer};
	assign pulses = {input1_edge_pulse, counter_reinit, count_step};
	tsm_slave_ctrl uut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.advanced_control_timer, .timer14_channel1_compare_out, .input1_filtered_raw,
		.filtered_input_1, .filtered_input_2, .input1_invert, .input2_invert,
		.ref_clear_pin_input, .filtered_external_trigger, .ref_clear_internal, .counter_enable,
		.trigger_output, .count_step, .count_down, .counter_reinit, .update_request,
		.input1_edge_pulse);
	tsm_far_side far_side (.core_clk, .want, .slow, .advanced_control_timer,
		.timer14_channel1_compare_out, .input1_filtered_raw, .filtered_input_1,
		.filtered_input_2, .ref_clear_pin_input, .filtered_external_trigger);
	initial begin
		forever #12.5 core_clk = ~core_clk;
	end
	// ----
	// tasks
	// ----
	task automatic give_verdict();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : give_verdict
	task automatic cmp_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, string s);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h", $time, s, got);
		end
	endtask : cmp_word
	task automatic cmp_bit(input logic got, input logic exp, input string s);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %b", $time, s, got);
		end
	endtask : cmp_bit
	task automatic cmp_lat(input int got, input int exp, input string s);
		checks++;
		if (got != exp) begin
			n_mismatch++;
			$display("BAD %0t %s delay %0d", $time, s, got);
		end
	endtask : cmp_lat
	task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : reg_write
	task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read
	// returns just after the edge at which the far side shows the new levels
	task automatic drive(input logic [5:0] w);
		@(posedge core_clk);
		want <= w;
		slow <= 2'($urandom_range(0, 3));
		for (int i = 0; i < 8; i++) begin
			@(posedge core_clk);
			#1;
			if (far === want)
				break;
		end
	endtask : drive
	// -1 means the pulse never came; a late or stray pulse shows as a wrong delay
	task automatic measure(input int k, output int lat, output logic dn, output logic up);
		lat = -1;
		for (int i = 1; i <= 6; i++) begin
			@(posedge core_clk);
			#1;
			if (lat < 0 && pulses[k] === 1'b1) begin
				lat = i;
				dn  = count_down;
				up  = update_request;
			end
		end
	endtask : measure
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			$display("BAD %0t run hung", $time);
			give_verdict();
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		logic [DATA_W-1:0] rd;
		logic [5:0]        w;
		logic              dn, up, a, b;
		int                lat, v, t, hit;
		void'($urandom(32'hBA0BC4F4));
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		reg_read(OFS_SLAVE_MODE, rd);
		cmp_word(rd, 32'h0, "reset value");
		v = $urandom();
		reg_write(OFS_SLAVE_MODE, 32'(v));
		reg_read(OFS_SLAVE_MODE, rd);
		cmp_word(rd, 32'(v) & 32'hFF, "readback");
		reg_read(8'h10, rd);
		cmp_word(rd, 32'h0, "unmapped");
		for (int m = 0; m < 2; m++)
			for (int s = 0; s < 8; s++) begin
				reg_write(OFS_SLAVE_MODE, 32'(m * 128 + s * 16 + 4));
				drive(pin_of[s]);
				measure(1, lat, dn, up);
				cmp_lat(lat, (s == 1 || s == 2 || s == 7) ? -1 : 1 + m + 32'(s == 4), "reinit");
				if (lat > 0)
					cmp_bit(up, 1'b1, "update");
				drive(6'h00);
				repeat (6) @(posedge core_clk);
			end
		for (int e = 0; e < 2; e++) begin
			drive(e ? 6'h00 : 6'h04);
			measure(2, lat, dn, up);
			cmp_lat(lat, 1, "edge pulse");
		end
		reg_write(OFS_SLAVE_MODE, 32'h54);
		input1_invert <= 1'b1;
		repeat (4) @(posedge core_clk);
		drive(6'h04);
		measure(1, lat, dn, up);
		cmp_lat(lat, -1, "inverted fall");
		drive(6'h00);
		measure(1, lat, dn, up);
		cmp_lat(lat, 1, "inverted rise");
		@(posedge core_clk);
		input1_invert <= 1'b0;
		for (int c = 0; c < 4; c++) begin
			reg_write(OFS_SLAVE_MODE, 32'(c % 2 * 8));
			drive({($urandom_range(0, 1) ? 2'b10 : 2'b01), 4'h0});
			repeat (2) @(posedge core_clk);
			#1 cmp_bit(ref_clear_internal, want[4 + c % 2], "clear source");
		end
		for (int m = 0; m < 2; m++) begin
			reg_write(OFS_COUNTER_CTRL, 32'h1);
			reg_write(OFS_SLAVE_MODE, 32'h0);
			repeat (2) @(posedge core_clk);
			#1 cmp_bit(counter_enable, 1'b1, "free run");
			reg_write(OFS_SLAVE_MODE, 32'(m * 128 + 32'h55));
			drive(6'h04);
			v = 0;
			while (counter_enable !== 1'b1 && v < 8) begin
				@(posedge core_clk);
				#1 v++;
			end
			cmp_bit(counter_enable, 1'b1, "gate opens");
			cmp_bit(trigger_output, 1'(m), "slave view");
			@(posedge core_clk);
			#1 cmp_bit(trigger_output, 1'b1, "slave view follows");
			drive(6'h00);
			repeat (4) @(posedge core_clk);
			#1 cmp_bit(counter_enable, 1'b0, "gate halts");
		end
		reg_write(OFS_COUNTER_CTRL, 32'h0);
		reg_write(OFS_SLAVE_MODE, 32'h56);
		drive(6'h04);
		drive(6'h00);
		repeat (3) @(posedge core_clk);
		#1 cmp_bit(counter_enable, 1'b1, "started");
		reg_read(OFS_COUNTER_CTRL, rd);
		cmp_word(rd, 32'h1, "run bit");
		reg_read(OFS_SLAVE_STATUS, rd);
		cmp_word(rd, 32'h6, "status");
		reg_write(OFS_SLAVE_MODE, 32'h07);
		repeat (3) begin
			drive(6'h01);
			measure(0, lat, dn, up);
			cmp_lat(lat, 1, "clock rise");
			drive(6'h00);
			measure(0, lat, dn, up);
			cmp_lat(lat, -1, "clock fall");
		end
		for (int e = 1; e < 4; e++) begin
			@(posedge core_clk);
			input2_invert <= 1'($urandom_range(0, 1));
			repeat (3) @(posedge core_clk);
			reg_write(OFS_SLAVE_MODE, 32'(e));
			repeat (4) begin
				t = $urandom_range(0, 1);
				w = want ^ (t ? 6'h08 : 6'h04);
				drive(w);
				measure(0, lat, dn, up);
				hit = e == 3 || e == 2 - t;
				a = w[2] ^ input1_invert;
				b = w[3] ^ input2_invert;
				cmp_lat(lat, hit ? 1 : -1, "encoder step");
				if (hit)
					cmp_bit(dn, t ? a == b : a != b, "encoder dir");
			end
		end
		give_verdict();
	end
endmodule : timer_slave_mode_controller_test
`default_nettype wire
